/* File: inc/tcs_params.svh */
// constants for the conversion scheduler and configuration registers
// Notes on behaviour
// - first config register reads at 0x03, writes at 0x09, via pointer.
// - second config register sits at 0x24; bits 6:0 reserved, read zero.
// - writing 1 to lock bit freezes lockable registers until reset.
// - rate/channel register reads at 0x04, writes at 0x0A.
// - low four rate bits pick interval, 16 s down to 31.25 ms.
// - rate codes 0xA and above mean back-to-back continuous conversions.
// - each interval start launches one conversion on every enabled channel.
// - rate register resets to 0x07, eight conversion sets per second.
// - rate bit 7 disables averaging; no averaging at three fastest rates.
// - rate bits 5:4 select round-robin, local, remote one or remote two.
// - first write byte loads pointer; next byte and reads use it.
// - remote view select bit 3 stays writable while locked.
// - standby bit 6 suspends conversions; register access stays alive.
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
// ==========================================================================
// register addresses
`define TCS_A_CFG1_RD 8'h03
`define TCS_A_CFG1_WR 8'h09
`define TCS_A_RATE_RD 8'h04
`define TCS_A_RATE_WR 8'h0A
`define TCS_A_CFG2 8'h24
// ==========================================================================
// field positions, reset values and rate codes
`define TCS_CFG1_STBY 6
`define TCS_CFG1_RSVD 4
`define TCS_CFG1_RVIEW 3
`define TCS_CFG2_LOCK 7
`define TCS_RATE_AVGD 7
`define TCS_RATE_RSVD 6
`define TCS_RST_CFG1 8'h00
`define TCS_RST_RATE 8'h07
`define TCS_RST_PTR 8'h00
`define TCS_CODE_SLOW 4'h9
`define TCS_CODE_CONT 4'hA
`define TCS_CODE_NOAVG 4'h8
// ==========================================================================
// timing
`define TCS_CLK_NS 10
`define TCS_BASE_US 31250
`define TCS_BASE_CYC (`TCS_BASE_US * 1000 / `TCS_CLK_NS)
`endif

/* File: inc/tcs_pkg.sv */
// types of the conversion scheduler
package tcs_pkg;
	typedef enum logic [2:0] {
		TCS_WAIT = 3'b001,
		TCS_CONV = 3'b010,
		TCS_STBY = 3'b100
	} tcs_state_e;

	// bit 0 local, bit 1 remote one, bit 2 remote two
	typedef struct packed {
		logic [2:0] chan_mask;
		logic avg_en;
	} tcs_conv_s;

	typedef struct packed {
		tcs_state_e state;
		logic [7:0] ptr;
		logic [7:0] cfg1;
		logic [7:0] rate;
		logic locked;
		logic [3:0] act_rate;
		logic [1:0] act_chan;
		logic [31:0] tick_cnt;
		logic [9:0] ivl_cnt;
		logic pending;
		logic [7:0] rd_data;
		logic start;
		tcs_conv_s conv;
	} tcs_regs_s;
endpackage : tcs_pkg

/* File: hw/tcs_sched.sv */
// configuration registers and conversion scheduler of the monitor
`timescale 1ns/10ps
`include "tcs_params.svh"
module tcs_sched
	import tcs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TCS_BASE_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// byte port from the serial engine
	input wire logic i_wr_stb,
	input wire logic i_wr_first,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	// measurement front end
	input wire logic i_conv_done,
	output logic o_conv_start,
	output tcs_conv_s o_conv,
	// configuration seen by other blocks
	output logic [7:0] o_cfg1,
	output logic o_locked,
	output logic o_standby
);

// ==========================================================================
// helpers

	// ticks of the 31.25 ms base per interval
	function automatic logic [9:0] ivl_ticks(input logic [3:0] code);
		logic [9:0] t;
		t = 10'h001;
		if (code < `TCS_CODE_SLOW) begin
			t = 10'h001 << (4'(`TCS_CODE_SLOW) - code);
		end
		return t;
	endfunction : ivl_ticks

	function automatic logic [2:0] chan_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h7;
		case (sel)
			2'h1: m = 3'h1;
			2'h2: m = 3'h2;
			2'h3: m = 3'h4;
			default: m = 3'h7;
		endcase
		return m;
	endfunction : chan_mask

	function automatic logic is_cont(input logic [3:0] code);
		return code >= `TCS_CODE_CONT;
	endfunction : is_cont

// ==========================================================================
// state

	tcs_regs_s st;
	tcs_regs_s next_st;
	logic stby;
	logic tick;
	logic ivl_end;

	assign stby = st.cfg1[`TCS_CFG1_STBY];
	assign tick = st.tick_cnt == 32'(TICK_CYCLES - 1);
	assign ivl_end = tick && (st.ivl_cnt + 10'h001 == ivl_ticks(st.act_rate));

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;

		// base timer; held at zero in standby so wake-up starts clean
		if (stby || st.state == TCS_STBY) begin
			next_st.tick_cnt = 32'h0;
			next_st.ivl_cnt = 10'h000;
		end else if (tick) begin
			next_st.tick_cnt = 32'h0;
			next_st.ivl_cnt = st.ivl_cnt + 10'h001;
			if (ivl_end) begin
				next_st.ivl_cnt = 10'h000;
				next_st.pending = 1'b1;
			end
		end else begin
			next_st.tick_cnt = st.tick_cnt + 32'h1;
		end

		case (st.state)
			TCS_WAIT: begin
				if (stby) begin
					next_st.state = TCS_STBY;
				end else if (st.pending) begin
					next_st.state = TCS_CONV;
				end
			end
			TCS_CONV: begin
				// a running conversion always finishes before standby
				if (i_conv_done) begin
					if (stby) begin
						next_st.state = TCS_STBY;
						next_st.pending = 1'b0;
					end else if (!is_cont(st.act_rate) && !st.pending) begin
						next_st.state = TCS_WAIT;
					end
				end
			end
			TCS_STBY: begin
				if (!stby) begin
					next_st.state = TCS_WAIT;
					next_st.pending = 1'b1;
				end
			end
			default: begin
				next_st.state = TCS_WAIT;
			end
		endcase

		// launch: new settings are sampled only here
		if (!stby && ((st.state == TCS_WAIT && st.pending) ||
				(st.state == TCS_CONV && i_conv_done &&
				(is_cont(st.act_rate) || st.pending)))) begin
			next_st.start = 1'b1;
			next_st.pending = 1'b0;
			next_st.act_rate = st.rate[3:0];
			next_st.act_chan = st.rate[5:4];
			next_st.conv.chan_mask = chan_mask(st.rate[5:4]);
			next_st.conv.avg_en = !st.rate[`TCS_RATE_AVGD] &&
				(st.rate[3:0] < `TCS_CODE_NOAVG);
			next_st.tick_cnt = 32'h0;
			next_st.ivl_cnt = 10'h000;
		end

		// register writes
		if (i_wr_stb) begin
			if (i_wr_first) begin
				next_st.ptr = i_wr_data;
			end else if (st.ptr == `TCS_A_CFG1_WR) begin
				if (st.locked) begin
					next_st.cfg1[`TCS_CFG1_RVIEW] =
						i_wr_data[`TCS_CFG1_RVIEW];
				end else begin
					next_st.cfg1 = i_wr_data;
					next_st.cfg1[`TCS_CFG1_RSVD] = 1'b0;
				end
			end else if (st.ptr == `TCS_A_RATE_WR) begin
				if (!st.locked) begin
					next_st.rate = i_wr_data;
					next_st.rate[`TCS_RATE_RSVD] = 1'b0;
				end
			end else if (st.ptr == `TCS_A_CFG2) begin
				if (i_wr_data[`TCS_CFG2_LOCK]) begin
					next_st.locked = 1'b1;
				end
			end
		end

		// read data follows the pointer; unmapped addresses read zero
		if (st.ptr == `TCS_A_CFG1_RD) begin
			next_st.rd_data = st.cfg1;
		end else if (st.ptr == `TCS_A_RATE_RD) begin
			next_st.rd_data = st.rate;
		end else if (st.ptr == `TCS_A_CFG2) begin
			next_st.rd_data = {st.locked, 7'h00};
		end else begin
			next_st.rd_data = 8'h00;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			st <= '0;
			st.state <= TCS_WAIT;
			st.ptr <= `TCS_RST_PTR;
			st.cfg1 <= `TCS_RST_CFG1;
			st.rate <= `TCS_RST_RATE;
			st.act_rate <= 4'(`TCS_RST_RATE);
			st.pending <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_rd_data = st.rd_data;
	assign o_conv_start = st.start;
	assign o_conv = st.conv;
	assign o_cfg1 = st.cfg1;
	assign o_locked = st.locked;
	assign o_standby = stby;

// ==========================================================================
// checks

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_ptr_load: assert property (
		i_wr_stb && i_wr_first |=> st.ptr == $past(i_wr_data))
		else $error("pointer not loaded from first byte");

	a_cfg1_read: assert property (
		st.ptr == `TCS_A_CFG1_RD |=> o_rd_data == $past(st.cfg1))
		else $error("config one read wrong");

	a_cfg2_rsvd: assert property (
		st.ptr == `TCS_A_CFG2 |=> o_rd_data[6:0] == 7'h00)
		else $error("reserved config two bits not zero");

	a_lock_sticky: assert property (
		st.locked |=> st.locked [*3])
		else $error("lock released without reset");

	a_lock_freeze: assert property (
		st.locked && i_wr_stb && !i_wr_first && st.ptr == `TCS_A_RATE_WR
		|=> $stable(st.rate))
		else $error("rate changed while locked");

	a_rate_read: assert property (
		st.ptr == `TCS_A_RATE_RD ##1 st.ptr == `TCS_A_RATE_RD
		|-> o_rd_data == $past(st.rate))
		else $error("rate read wrong");

	a_rate_reset: assert property (
		$fell(i_sys_rst) |-> st.rate == `TCS_RST_RATE)
		else $error("rate reset value wrong");

	a_rview_free: assert property (
		i_wr_stb && !i_wr_first && st.ptr == `TCS_A_CFG1_WR
		|=> st.cfg1[`TCS_CFG1_RVIEW] == $past(i_wr_data[`TCS_CFG1_RVIEW]))
		else $error("view select not written");

	a_stby_quiet: assert property (
		o_conv_start |-> !$past(stby))
		else $error("conversion launched in standby");

	// expected mask worked out here, not through the decoder function
	a_chan_mask: assert property (
		o_conv_start |-> ($past(st.rate[5:4]) == 2'h0 ?
		o_conv.chan_mask == 3'h7 :
		o_conv.chan_mask == 3'h1 << ($past(st.rate[5:4]) - 2'h1)))
		else $error("channel mask mismatch");

	a_fast_noavg: assert property (
		o_conv_start && st.act_rate >= `TCS_CODE_NOAVG |-> !o_conv.avg_en)
		else $error("averaging at fast rate");

	a_cont_back: assert property (
		st.state == TCS_CONV && i_conv_done && is_cont(st.act_rate) && !stby
		|=> o_conv_start)
		else $error("continuous mode did not relaunch");

	// standby entered in the pending cycle legally holds the launch back
	a_ivl_launch: assert property (
		st.state == TCS_WAIT && !st.pending && ivl_end && !stby ##1 !stby
		|=> o_conv_start)
		else $error("interval end without launch");

	c_round_robin: cover property (o_conv_start && st.act_chan == 2'h0);
	c_continuous: cover property (o_conv_start && is_cont(st.act_rate));
	c_lock_set: cover property ($rose(st.locked));
	c_standby: cover property (st.state == TCS_STBY ##1 st.state == TCS_WAIT);

endmodule : tcs_sched

/* File: tb/tcs_front_model.sv */
// behavioural measurement front end answering each launch
`timescale 1ns/10ps
module tcs_front_model (
	// clock
	input wire logic i_core_clk,
	// launch and answer
	input wire logic i_start,
	input wire logic [7:0] i_delay,
	output logic o_done
);
	initial o_done = 1'b0;
	// one done per launch; sampled off the edge to avoid a race
	always @(negedge i_core_clk) begin
		if (i_start === 1'b1) begin
			repeat (i_delay) @(posedge i_core_clk);
			o_done <= 1'b1;
			@(posedge i_core_clk);
			o_done <= 1'b0;
		end
	end
endmodule : tcs_front_model

/* File: tb/test_tcs_sched.sv */
// self-checking bench of the configuration registers and scheduler
`timescale 1ns/10ps
module test_tcs_sched;
	import tcs_pkg::*;
	localparam int TICK = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic stb = 1'b0;
	logic first = 1'b0;
	logic [7:0] data = 8'h00;
	logic [7:0] dly = 8'h02;
	logic look = 1'b0;
	logic [7:0] rd_data;
	logic done;
	logic start;
	tcs_conv_s conv;
	logic [7:0] cfg1;
	logic locked;
	logic standby;
	logic [7:0] q[$];
	logic [7:0] qc[$];
	logic [7:0] v;
	int cyc = 0;
	int t0;
	int ivl;
	int n;
	int n_mismatch = 0;
	int compares = 0;

	tcs_sched #(.TICK_CYCLES(TICK)) tcs_sched_i (
		.i_core_clk(clk), .i_sys_rst(rst), .i_wr_stb(stb),
		.i_wr_first(first), .i_wr_data(data), .o_rd_data(rd_data),
		.i_conv_done(done), .o_conv_start(start), .o_conv(conv),
		.o_cfg1(cfg1), .o_locked(locked), .o_standby(standby)
	);
	tcs_front_model tcs_front_model_i (
		.i_core_clk(clk), .i_start(start), .i_delay(dly), .o_done(done)
	);

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	// ==========================================================
	// tasks
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task report_and_stop();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic wr(logic [7:0] p, logic [7:0] d);
		@(posedge clk);
		stb <= 1'b1;
		first <= 1'b1;
		data <= p;
		@(posedge clk);
		first <= 1'b0;
		data <= d;
		@(posedge clk);
		stb <= 1'b0;
	endtask : wr

	// data lands two edges after the pointer byte
	task automatic rd(logic [7:0] p, logic [7:0] exp);
		@(posedge clk);
		stb <= 1'b1;
		first <= 1'b1;
		data <= p;
		q.push_back(exp);
		@(posedge clk);
		stb <= 1'b0;
		@(posedge clk);
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : rd

	task automatic wait_start();
		int k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (start !== 1'b1 && k < 5000);
		if (start !== 1'b1) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : wait_start

	function automatic logic [7:0] exp_conv(logic [7:0] r);
		logic [2:0] m;
		m = (r[5:4] == 2'd0) ? 3'h7 : 3'h1 << (r[5:4] - 2'd1);
		return {4'h0, m, !r[7] && r[3:0] < 4'h8};
	endfunction : exp_conv

	// ==========================================================
	// result watcher
	always @(negedge clk) begin
		if (look)
			check(rd_data, q.pop_front());
		if (start === 1'b1 && qc.size() > 0)
			check({4'h0, conv}, qc.pop_front());
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(81170));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h07);
		rd(8'h24, 8'h00);
		rd(8'h0A, 8'h00);
		rd(8'h55, 8'h00);
		// every interval rate code 0 to 9, random channel and averaging; bit 6 kept 0
		for (int c = 0; c < 10; c++) begin
			v = {1'($urandom), 1'b0, 2'($urandom), 4'(c)};
			ivl = (1 << (9 - c)) * TICK;
			wait_start();
			wr(8'h0A, v);
			qc.push_back(exp_conv(v));
			wait_start();
			t0 = cyc;
			wait_start();
			check(8'(cyc - t0 >= ivl && cyc - t0 <= ivl + 2), 8'h01);
			rd(8'h04, v);
		end
		// continuous, with a slow front end
		dly <= 8'h05;
		// align first so no old-mode start lands on the write edge
		wait_start();
		wr(8'h0A, 8'h1A);
		qc.push_back(8'h02);
		wait_start();
		t0 = cyc;
		wait_start();
		check(8'(cyc - t0 >= 6 && cyc - t0 <= 8), 8'h01);
		// standby halts launches but not register access
		wr(8'h09, 8'h40);
		rd(8'h03, 8'h40);
		check(cfg1, 8'h40);
		check({7'h0, standby}, 8'h01);
		repeat (20) @(negedge clk);
		n = 0;
		repeat (100) begin
			@(negedge clk);
			if (start === 1'b1)
				n++;
		end
		check(8'(n), 8'h00);
		wr(8'h09, 8'h00);
		wait_start();
		// lock freezes all but the view select, set-only
		wr(8'h24, 8'h80);
		rd(8'h24, 8'h80);
		check({7'h0, locked}, 8'h01);
		wr(8'h09, 8'hFF);
		rd(8'h03, 8'h08);
		check(cfg1, 8'h08);
		wr(8'h0A, 8'h31);
		rd(8'h04, 8'h1A);
		wr(8'h24, 8'h00);
		rd(8'h24, 8'h80);
		// only a reset releases the lock
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h24, 8'h00);
		rd(8'h04, 8'h07);
		report_and_stop();
	end
endmodule : test_tcs_sched
